// ===== pkg/rsc_pkg.sv
package rsc_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int RSC_CNT_W = 16;
  localparam int RSC_SYNC_W = 2;
  localparam int RSC_SYNC_CLK = 0;
  localparam int RSC_SYNC_GATE = 1;
  localparam int RSC_SYS_CLK_NS = 50;

  // ****************************************
  // Counter values
  // ****************************************
  localparam logic [15:0] RSC_CNT_RST = 16'h0000;
  localparam logic [15:0] RSC_BIN_TOP = 16'hffff;
  localparam logic [15:0] RSC_BCD_TOP = 16'h9999;
  localparam logic [15:0] RSC_CNT_ONE = 16'h0001;
  localparam logic [15:0] RSC_CNT_TWO = 16'h0002;
  localparam logic [3:0] RSC_BCD_TEN = 4'ha;

  // ****************************************
  // Counting modes
  // ****************************************
  typedef enum logic [2:0] {
    RSC_M_TERM = 3'b000,
    RSC_M_ONESHOT = 3'b001,
    RSC_M_RATE = 3'b010,
    RSC_M_SQUARE = 3'b011,
    RSC_M_SWSTROBE = 3'b100,
    RSC_M_HWSTROBE = 3'b101
  } rsc_mode_t;

  localparam rsc_mode_t RSC_MODE_RST = RSC_M_HWSTROBE;
  localparam logic RSC_OUT_RST = 1'b1;

endpackage : rsc_pkg

// ===== rtl/rsc_dec.sv
`timescale 1ns/100ps

module rsc_dec
  import rsc_pkg::*;
(
  input wire logic [RSC_CNT_W-1:0] val_i,
  input wire logic bcd_i,
  input wire logic by_two_i,
  output logic [RSC_CNT_W-1:0] val_o
);

  // ****************************************
  // Binary and decimal step down
  // ****************************************
  localparam int DIGITS = RSC_CNT_W / 4;

  logic [RSC_CNT_W-1:0] bin_w;
  logic [RSC_CNT_W-1:0] bcd_w;
  logic [DIGITS:0] borrow_w;
  logic [1:0] step_w;

  assign step_w = by_two_i ? 2'd2 : 2'd1;
  assign bin_w = val_i - {{(RSC_CNT_W-2){1'b0}}, step_w};
  assign borrow_w[0] = 1'b0;

  // Each digit rolls 0 to 9
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_digit
      logic [3:0] dig_w;
      logic [3:0] sub_w;
      logic [3:0] raw_w;
      assign dig_w = val_i[4*g +: 4];
      assign sub_w = (g == 0) ? {2'b00, step_w} : {3'b000, borrow_w[g]};
      assign borrow_w[g+1] = (dig_w < sub_w);
      assign raw_w = dig_w - sub_w;
      assign bcd_w[4*g +: 4] = borrow_w[g+1] ? raw_w + RSC_BCD_TEN : raw_w;
    end
  endgenerate

  assign val_o = bcd_i ? bcd_w : bin_w;

endmodule : rsc_dec

// ===== rtl/rsc_counter.sv
`timescale 1ns/100ps

// Function
// - Hardware strobe mode: output idles high, strobes low one pulse at expiry.
// - Hardware strobe mode waits for trigger, loads next pulse without decrement, N+1 pulses.
// - In modes 1,2,3,5 every trigger reloads the initial count on the next count pulse.
// - In strobe mode the trigger never changes the output level directly.
// - In modes 1 and 5 a new count mid-sequence only takes effect on a later trigger.
// - Gate sampled on count clock rise; level enables counting in 0,2,3,4.
// - Gate rising edge starts counting in 1,2,3,5; one-shot output low next pulse.
// - Gate rise sets capture flop, sampled and cleared on next count clock rise.
// - Modes 2 and 3: gate low stops counting and forces output high at once.
// - Least initial count is 1, or 2 in modes 2 and 3.
// - Initial count zero acts as 2^16 binary or 10^4 decimal.
// - Mode write resets control logic and sets output to initial level at once.
// - Loading and decrementing happen on count clock falling edge.
// - Modes 0,1,4,5 wrap from zero to FFFF or 9999 and continue.
// - Modes 2 and 3 reload the initial count at period end, forever.
// - A pulse is count clock rise then fall; trigger is gate rise.
module rsc_counter
  import rsc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic cnt_clk_i,
  input wire logic gate_i,
  input wire logic mode_wr_i,
  input wire logic [2:0] mode_i,
  input wire logic bcd_i,
  input wire logic count_wr_i,
  input wire logic [RSC_CNT_W-1:0] count_i,
  output logic out_o,
  output logic [RSC_CNT_W-1:0] count_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [RSC_SYNC_W-1:0] pin_w;
  logic [RSC_SYNC_W-1:0] s1_q;
  logic [RSC_SYNC_W-1:0] s2_q;
  logic [RSC_SYNC_W-1:0] s3_q;
  logic [RSC_SYNC_W-1:0] lvl_q;
  logic [RSC_SYNC_W-1:0] lvl_d;

  assign pin_w = {gate_i, cnt_clk_i};
  genvar g;
  generate
    for (g = 0; g < RSC_SYNC_W; g++) begin : g_sync
      assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_w[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          lvl_q[g] <= lvl_d[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Edges and decode
  // ****************************************
  logic cnt_rise_w;
  logic cnt_fall_w;
  logic gate_rise_w;
  logic gate_lvl_w;
  assign cnt_rise_w = lvl_d[RSC_SYNC_CLK] & ~lvl_q[RSC_SYNC_CLK];
  assign cnt_fall_w = ~lvl_d[RSC_SYNC_CLK] & lvl_q[RSC_SYNC_CLK];
  assign gate_rise_w = lvl_d[RSC_SYNC_GATE] & ~lvl_q[RSC_SYNC_GATE];
  assign gate_lvl_w = lvl_q[RSC_SYNC_GATE];
  rsc_mode_t mode_q;
  logic bcd_q;
  logic [RSC_CNT_W-1:0] cr_q;
  logic [RSC_CNT_W-1:0] cnt_q;
  logic out_q;
  logic have_q;
  logic pending_q;
  logic started_q;
  logic armed_q;
  logic tail_q;
  logic trig_flag_q;
  logic trig_smp_q;
  logic gate_s_q;
  rsc_mode_t mode_new_w;
  logic is15_w;
  logic is23_w;
  logic load_w;
  logic en_w;
  logic exp3_w;
  logic init_out_w;
  logic [RSC_CNT_W-1:0] ld_val_w;
  logic [RSC_CNT_W-1:0] dec_w;
  // Codes 6 and 7 alias modes 2 and 3
  assign mode_new_w = (mode_i[2:1] == 2'b11) ? rsc_mode_t'({1'b0, mode_i[1:0]}) :
                      rsc_mode_t'(mode_i);
  assign init_out_w = (mode_new_w != RSC_M_TERM);
  assign is15_w = (mode_q == RSC_M_ONESHOT) || (mode_q == RSC_M_HWSTROBE);
  assign is23_w = (mode_q == RSC_M_RATE) || (mode_q == RSC_M_SQUARE);
  // Edge trigger in 1,2,3,5; hardware strobe mode waits for it
  assign load_w = is15_w ? (trig_smp_q & have_q) :
                  is23_w ? ((pending_q & ~started_q) | (trig_smp_q & have_q)) :
                  pending_q;
  assign en_w = is15_w | gate_s_q;
  assign ld_val_w = (mode_q == RSC_M_SQUARE) ? {cr_q[RSC_CNT_W-1:1], 1'b0} : cr_q;
  assign exp3_w = tail_q | ((cnt_q == RSC_CNT_TWO) & ~(cr_q[0] & out_q));
  // Zero steps down to the top value, giving full range
  rsc_dec u_dec (
    .val_i(cnt_q),
    .bcd_i(bcd_q),
    .by_two_i(mode_q == RSC_M_SQUARE),
    .val_o(dec_w)
  );

  // ****************************************
  // Gate sampling
  // ****************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trig_flag_q <= 1'b0;
      trig_smp_q <= 1'b0;
      gate_s_q <= 1'b0;
    end else if (mode_wr_i) begin
      trig_flag_q <= 1'b0;
      trig_smp_q <= 1'b0;
    end else begin
      if (gate_rise_w) begin
        trig_flag_q <= 1'b1;
      end else if (cnt_rise_w) begin
        trig_flag_q <= 1'b0;
      end
      if (cnt_rise_w) begin
        trig_smp_q <= trig_flag_q;
        gate_s_q <= gate_lvl_w;
      end else if (cnt_fall_w) begin
        trig_smp_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Counting element
  // ****************************************
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= RSC_MODE_RST;
      bcd_q <= 1'b0;
      cr_q <= RSC_CNT_RST;
      cnt_q <= RSC_CNT_RST;
      out_q <= RSC_OUT_RST;
      have_q <= 1'b0;
      pending_q <= 1'b0;
      started_q <= 1'b0;
      armed_q <= 1'b0;
      tail_q <= 1'b0;
    end else if (mode_wr_i) begin
      // Immediate control reset
      mode_q <= mode_new_w;
      bcd_q <= bcd_i;
      out_q <= init_out_w;
      have_q <= 1'b0;
      pending_q <= 1'b0;
      started_q <= 1'b0;
      armed_q <= 1'b0;
      tail_q <= 1'b0;
    end else begin
      if (cnt_fall_w && load_w) begin
        cnt_q <= ld_val_w;
        started_q <= 1'b1;
        pending_q <= 1'b0;
        armed_q <= 1'b1;
        tail_q <= 1'b0;
        if (mode_q == RSC_M_ONESHOT) begin
          out_q <= 1'b0;
        end else if (mode_q != RSC_M_TERM) begin
          out_q <= 1'b1;
        end
      end else if (cnt_fall_w && started_q && en_w) begin
        unique case (mode_q)
          RSC_M_TERM: begin
            cnt_q <= dec_w;
            if (cnt_q == RSC_CNT_ONE) begin
              out_q <= 1'b1;
            end
          end
          RSC_M_ONESHOT: begin
            cnt_q <= dec_w;
            if (cnt_q == RSC_CNT_ONE && armed_q) begin
              out_q <= 1'b1;
              armed_q <= 1'b0;
            end
          end
          RSC_M_RATE: begin
            // Count below 2 is host error here
            if (cnt_q == RSC_CNT_ONE) begin
              cnt_q <= cr_q;
              out_q <= 1'b1;
              pending_q <= 1'b0;
            end else begin
              cnt_q <= dec_w;
              if (cnt_q == RSC_CNT_TWO) begin
                out_q <= 1'b0;
              end
            end
          end
          RSC_M_SQUARE: begin
            if (exp3_w) begin
              cnt_q <= ld_val_w;
              out_q <= ~out_q;
              tail_q <= 1'b0;
              pending_q <= 1'b0;
            end else begin
              cnt_q <= dec_w;
              tail_q <= (cnt_q == RSC_CNT_TWO) & cr_q[0] & out_q;
            end
          end
          RSC_M_SWSTROBE,
          RSC_M_HWSTROBE: begin
            cnt_q <= dec_w;
            if (!out_q) begin
              out_q <= 1'b1;
            end else if (cnt_q == RSC_CNT_ONE && armed_q) begin
              out_q <= 1'b0;
              armed_q <= 1'b0;
            end
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
      // Gate low in periodic modes forces output high
      if (is23_w && !gate_lvl_w) begin
        out_q <= 1'b1;
      end
      if (count_wr_i) begin
        cr_q <= count_i;
        have_q <= 1'b1;
        pending_q <= 1'b1;
        if (mode_q == RSC_M_TERM) begin
          out_q <= 1'b0;
        end
      end
    end
  end

  assign out_o = out_q;
  assign count_o = cnt_q;

  // ****************************************
  // Checks
  // ****************************************
  a_strobe_one_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (mode_q == RSC_M_HWSTROBE && !out_q && cnt_fall_w && !mode_wr_i) |=> out_q)
    else $error("strobe lasted more than one pulse");
  a_mode_write_init: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    mode_wr_i |=> (out_q == $past(init_out_w) && !started_q && !pending_q))
    else $error("mode write did not reset channel");
  a_trig_capture: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (gate_rise_w && !mode_wr_i) |=> trig_flag_q)
    else $error("trigger edge not captured");
  a_gate_low_high: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (is23_w && !gate_lvl_w && !mode_wr_i && !(count_wr_i && mode_q == RSC_M_TERM))
    |=> out_q)
    else $error("gate low did not force output high");
  a_gate_blocks_dec: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (cnt_fall_w && !load_w && !gate_s_q && !is15_w && !mode_wr_i) |=> $stable(cnt_q))
    else $error("counted with gate low");
  a_fall_only_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !cnt_fall_w |=> $stable(cnt_q))
    else $error("count changed off falling edge");
  a_trig_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (mode_q == RSC_M_HWSTROBE && cnt_fall_w && trig_smp_q && have_q && !mode_wr_i)
    |=> cnt_q == $past(cr_q))
    else $error("trigger did not reload count");
  a_trig_no_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (mode_q == RSC_M_HWSTROBE && !cnt_fall_w && !mode_wr_i) |=> $stable(out_q))
    else $error("gate changed strobe output");
  a_wrap_top: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (is15_w && cnt_fall_w && started_q && !load_w && cnt_q == RSC_CNT_RST && !mode_wr_i)
    |=> cnt_q == ($past(bcd_q) ? RSC_BCD_TOP : RSC_BIN_TOP))
    else $error("counter did not wrap to top");
  a_rate_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (mode_q == RSC_M_RATE && cnt_fall_w && started_q && gate_s_q && !load_w
     && cnt_q == RSC_CNT_ONE && !mode_wr_i) |=> (cnt_q == $past(cr_q) && out_q))
    else $error("rate mode did not reload");

endmodule : rsc_counter

// ===== verif/rsc_far_end.sv
`timescale 1ns/100ps

// ****************************************
// Count clock and gate source
// ****************************************
module rsc_far_end (
  input wire logic sys_clk_i,
  output logic cnt_clk_o,
  output logic gate_o
);
  initial begin
    cnt_clk_o = 1'b0;
    gate_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : wait_clk

  // Rise then fall, each held past the input filter
  task automatic pulse();
    cnt_clk_o = 1'b1;
    wait_clk(6);
    cnt_clk_o = 1'b0;
    wait_clk(6);
  endtask : pulse

  // Short gate pulse while the count clock is low
  task automatic trigger();
    gate_o = 1'b1;
    wait_clk(4);
    gate_o = 1'b0;
    wait_clk(4);
  endtask : trigger

  task automatic set_gate(input logic v);
    gate_o = v;
    wait_clk(8);
  endtask : set_gate
endmodule : rsc_far_end

// ===== verif/retriggerable_strobe_counter_tb.sv
`timescale 1ns/100ps

// ****************************************
// Bench top
// ****************************************
module retriggerable_strobe_counter_tb
  import rsc_pkg::*;
;
  typedef struct {string name; logic use_cnt; logic [15:0] cnt; logic out;} rsc_note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cnt_clk;
  logic gate;
  logic mode_wr = 1'b0;
  logic [2:0] mode = 3'h0;
  logic bcd = 1'b0;
  logic count_wr = 1'b0;
  logic [15:0] count = 16'h0000;
  logic out;
  logic [15:0] cnt;
  logic chk_q = 1'b0;
  rsc_note_t notes[$];
  rsc_note_t note;
  int mismatches = 0;
  int checked = 0;
  logic [15:0] r;

  always #(RSC_SYS_CLK_NS / 2) sys_clk = ~sys_clk;

  rsc_far_end i_far (.sys_clk_i(sys_clk), .cnt_clk_o(cnt_clk), .gate_o(gate));

  rsc_counter i_dut (
    .sys_clk_i(sys_clk),
    .reset_i(reset),
    .cnt_clk_i(cnt_clk),
    .gate_i(gate),
    .mode_wr_i(mode_wr),
    .mode_i(mode),
    .bcd_i(bcd),
    .count_wr_i(count_wr),
    .count_i(count),
    .out_o(out),
    .count_o(cnt)
  );

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic expect_v(input string name, input logic uc, input logic [15:0] c, input logic o);
    notes.push_back('{name, uc, c, o});
    chk_q = 1'b1;
    step(1);
    chk_q = 1'b0;
  endtask : expect_v

  task automatic wr_mode(input logic [2:0] m, input logic b);
    mode = m;
    bcd = b;
    mode_wr = 1'b1;
    step(1);
    mode_wr = 1'b0;
    step(1);
  endtask : wr_mode

  task automatic wr_count(input logic [15:0] v);
    count = v;
    count_wr = 1'b1;
    step(1);
    count_wr = 1'b0;
    step(1);
  endtask : wr_count

  always @(negedge sys_clk) begin
    if (chk_q) begin
      note = notes.pop_front();
      if (note.use_cnt) begin
        check({note.name, " count"}, cnt, note.cnt);
      end
      check({note.name, " out"}, {15'h0000, out}, {15'h0000, note.out});
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    r = 16'h0000;
    void'($urandom(38));
    step(3);
    reset = 1'b0;
    step(1);
    expect_v("rst", 1'b1, 16'h0000, 1'b1);
    wr_mode(RSC_M_HWSTROBE, 1'b0);
    expect_v("m5 init", 1'b1, 16'h0000, 1'b1);
    wr_count(16'h0003);
    i_far.pulse();
    i_far.pulse();
    expect_v("m5 idle", 1'b1, 16'h0000, 1'b1);
    i_far.trigger();
    expect_v("m5 trig", 1'b1, 16'h0000, 1'b1);
    i_far.pulse();
    expect_v("m5 load", 1'b1, 16'h0003, 1'b1);
    i_far.pulse();
    expect_v("m5 c2", 1'b1, 16'h0002, 1'b1);
    i_far.pulse();
    expect_v("m5 c1", 1'b1, 16'h0001, 1'b1);
    i_far.pulse();
    expect_v("m5 strobe", 1'b1, 16'h0000, 1'b0);
    i_far.pulse();
    expect_v("m5 wrap", 1'b1, RSC_BIN_TOP, 1'b1);
    wr_count(16'h0005);
    i_far.trigger();
    i_far.pulse();
    expect_v("m5 reload", 1'b1, 16'h0005, 1'b1);
    i_far.pulse();
    wr_count(16'h0002);
    i_far.pulse();
    expect_v("m5 keep", 1'b1, 16'h0003, 1'b1);
    i_far.trigger();
    i_far.pulse();
    expect_v("m5 retrig", 1'b1, 16'h0002, 1'b1);
    i_far.pulse();
    i_far.pulse();
    expect_v("m5 late", 1'b1, 16'h0000, 1'b0);
    wr_mode(RSC_M_ONESHOT, 1'b0);
    expect_v("m1 init", 1'b0, 16'h0000, 1'b1);
    wr_count(16'h0002);
    i_far.trigger();
    i_far.pulse();
    expect_v("m1 low", 1'b1, 16'h0002, 1'b0);
    wr_mode(RSC_M_RATE, 1'b0);
    expect_v("m2 init", 1'b0, 16'h0000, 1'b1);
    wr_count(16'h0003);
    i_far.set_gate(1'b1);
    i_far.pulse();
    expect_v("m2 load", 1'b1, 16'h0003, 1'b1);
    i_far.pulse();
    i_far.pulse();
    expect_v("m2 low", 1'b1, 16'h0001, 1'b0);
    i_far.set_gate(1'b0);
    expect_v("m2 gate", 1'b1, 16'h0001, 1'b1);
    i_far.set_gate(1'b1);
    i_far.pulse();
    expect_v("m2 restart", 1'b1, 16'h0003, 1'b1);
    i_far.pulse();
    i_far.pulse();
    i_far.pulse();
    expect_v("m2 period", 1'b1, 16'h0003, 1'b1);
    wr_mode(RSC_M_TERM, 1'b0);
    expect_v("m0 init", 1'b0, 16'h0000, 1'b0);
    i_far.set_gate(1'b0);
    wr_count(16'h0005);
    i_far.pulse();
    i_far.pulse();
    expect_v("m0 held", 1'b1, 16'h0005, 1'b0);
    i_far.set_gate(1'b1);
    i_far.pulse();
    expect_v("m0 run", 1'b1, 16'h0004, 1'b0);
    wr_mode(3'h7, 1'b0);
    wr_count(16'h0004);
    i_far.pulse();
    expect_v("m3 load", 1'b1, 16'h0004, 1'b1);
    i_far.pulse();
    i_far.pulse();
    expect_v("m3 half", 1'b1, 16'h0004, 1'b0);
    i_far.set_gate(1'b0);
    expect_v("m3 gate", 1'b1, 16'h0004, 1'b1);
    i_far.set_gate(1'b1);
    wr_mode(RSC_M_SWSTROBE, 1'b1);
    wr_count(16'h0010);
    i_far.pulse();
    i_far.pulse();
    expect_v("bcd digit", 1'b1, 16'h0009, 1'b1);
    wr_count(16'h0000);
    i_far.pulse();
    i_far.pulse();
    expect_v("bcd max", 1'b1, RSC_BCD_TOP, 1'b1);
    wr_mode(RSC_M_SWSTROBE, 1'b0);
    wr_count(16'h0000);
    i_far.pulse();
    i_far.pulse();
    expect_v("bin max", 1'b1, RSC_BIN_TOP, 1'b1);
    for (int i = 0; i < 3; i++) begin
      r = 16'($urandom_range(16'hffff, 2));
      wr_count(r);
      i_far.pulse();
      i_far.pulse();
      expect_v("m4 rand", 1'b1, r - 16'h0001, 1'b1);
    end
    step(2);
    give_verdict();
  end
endmodule : retriggerable_strobe_counter_tb
